//--- shared/adcrc_pkg.sv
// Constants, field layouts and types of the converter register controller.
// Shared by the controller and its synchroniser; no surroundings assumed.
package adcrc_pkg;

  localparam int          ADCRC_WORD_W   = 24;
  localparam int          ADCRC_SETUP_W  = 12;
  localparam logic [23:0] CFG_RST_VAL    = 24'h000040;
  localparam logic [23:0] OFS_RST_VAL    = 24'h000000;
  localparam logic [23:0] GAIN_RST_VAL   = 24'h400000;
  localparam logic [23:0] SETUP_RST_VAL  = 24'h000000;
  // Seventeen meaningful configuration bits, 19 down to 3.
  localparam logic [23:0] CFG_USED_MASK  = 24'h0ffff8;
  localparam int          CFG_DONE_BIT   = 19;
  localparam int          CFG_MULTI_BIT  = 15;
  localparam int          CFG_LOOP_BIT   = 14;
  localparam int          CFG_DEPTH_LSB  = 10;
  localparam int          CFG_DEPTH_W    = 4;
  localparam int          CFG_RESET_BIT  = 7;
  localparam int          CFG_VALID_BIT  = 6;
  localparam logic [23:0] CFG_WR_MASK    = 24'h07ff38;

  localparam logic [7:0]  INIT_ONES_BYTE = 8'hff;
  localparam logic [7:0]  INIT_END_BYTE  = 8'hfe;
  localparam logic [3:0]  INIT_ONES_CNT  = 4'hf;
  localparam logic [7:0]  FIFO_POP_BYTE  = 8'h00;

  localparam int          CMD_TYPE_BIT   = 7;
  localparam int          CMD_CH_LSB     = 4;
  localparam int          CMD_READ_BIT   = 3;
  localparam int          CMD_PTR_LSB    = 3;
  localparam int          SETUP_CH_LSB   = 0;

  localparam logic [2:0]  REG_OFS        = 3'h1;
  localparam logic [2:0]  REG_GAIN       = 3'h2;
  localparam logic [2:0]  REG_CFG        = 3'h3;
  localparam logic [2:0]  REG_SETUP      = 3'h5;

  localparam logic [2:0]  OP_NORMAL      = 3'h0;
  localparam logic [2:0]  OP_SELF_OFS    = 3'h1;
  localparam logic [2:0]  OP_SELF_GAIN   = 3'h2;
  localparam logic [2:0]  OP_SYS_OFS     = 3'h5;
  localparam logic [2:0]  OP_SYS_GAIN    = 3'h6;

  localparam logic [4:0]  TX_LAST_BIT    = 5'h17;

  typedef enum logic [1:0] {
    ST_INIT,
    ST_CMD,
    ST_WDATA
  } adcrc_state_t;

endpackage

//--- core/adcrc_sync.sv
// Two-stage level synchroniser into the domain of clk.
// Assumes d is a quasi-static level from another clock domain.
`timescale 1ns/1ps
module adcrc_sync
  import adcrc_pkg::*;
(
  input  wire logic clk,
  input  wire logic d,
  output logic      q
);

  logic meta_r;
  logic meta_nxt;
  logic q_r;
  logic q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge clk) begin
    meta_r <= meta_nxt;
    q_r    <= q_nxt;
  end

  assign q = q_r;

endmodule

//--- core/adcrc_ctrl.sv
// Register controller of a multi-channel converter: serial link, register
// file, command decode, conversion sequencer and result FIFO.
// Assumes a front end that answers conv_req with one conv_done pulse.
`timescale 1ns/1ps
module adcrc_ctrl
  import adcrc_pkg::*;
#(
  parameter int NCH        = 4,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        link_clk,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             conv_req,
  output logic [11:0]      conv_setup,
  output logic [2:0]       conv_op,
  input  wire logic        conv_done,
  input  wire logic [23:0] conv_result,
  output logic [23:0]      cal_offset,
  output logic [23:0]      cal_gain,
  output logic [23:0]      cfg_out
);

  localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1;
  localparam int FAW = $clog2(FIFO_DEPTH);

  // Link domain: byte receiver and word transmitter on the host clock.
  logic        lrst_r;
  logic [2:0]  lcnt_r, lcnt_nxt;
  logic [7:0]  lsh_r, lsh_nxt, lbyte_r, lbyte_nxt;
  logic        ltgl_r, ltgl_nxt, lseen_r, lseen_nxt, sdo_r, sdo_nxt;
  logic [23:0] ltx_r, ltx_nxt;
  logic [4:0]  ltxc_r, ltxc_nxt;
  logic        ltx_req_s, ldone_s;

  // Core domain state.
  adcrc_state_t state_r, state_nxt;
  logic [23:0] ofs_r   [NCH];
  logic [23:0] ofs_nxt [NCH];
  logic [23:0] gain_r  [NCH];
  logic [23:0] gain_nxt[NCH];
  logic [23:0] setup_r [NCH];
  logic [23:0] setup_nxt[NCH];
  logic [23:0] fifo_r  [FIFO_DEPTH];
  logic [23:0] fifo_nxt[FIFO_DEPTH];
  logic [23:0] cfg_r, cfg_nxt, wdata_r, wdata_nxt, txw_r, txw_nxt;
  logic [23:0] calo_r, calo_nxt, calg_r, calg_nxt;
  logic [7:0]  cmd_r, cmd_nxt;
  logic [3:0]  ones_r, ones_nxt, ptr_r, ptr_nxt;
  logic [1:0]  wcnt_r, wcnt_nxt;
  logic [FAW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [FAW:0]   fcnt_r, fcnt_nxt;
  logic        txt_r, txt_nxt, rsm_r, rsm_nxt, busy_r, busy_nxt;
  logic        scan_r, scan_nxt, done_r, done_nxt, req_r, req_nxt;
  logic [11:0] cset_r, cset_nxt;
  logic [2:0]  cop_r, cop_nxt;
  logic        rx_s, rx_prev_r, rx_stb;
  logic [7:0]  rxb;
  logic        push, pop, dset, dclr, soft_rst, cfg_apply, fifo_full;
  logic [CHW-1:0] cch;

  adcrc_sync u_tx_sync (.clk(link_clk), .d(txt_r),  .q(ltx_req_s));
  adcrc_sync u_dn_sync (.clk(link_clk), .d(done_r), .q(ldone_s));
  adcrc_sync u_rx_sync (.clk(clock),    .d(ltgl_r), .q(rx_s));

  always_comb begin
    lsh_nxt   = {lsh_r[6:0], sdi};
    lcnt_nxt  = lcnt_r + 3'h1;
    lbyte_nxt = lbyte_r;
    ltgl_nxt  = ltgl_r;
    lseen_nxt = lseen_r;
    ltx_nxt   = {ltx_r[22:0], 1'b0};
    ltxc_nxt  = ltxc_r;
    sdo_nxt   = ~ldone_s;
    if (lcnt_r == 3'h7) begin
      lbyte_nxt = {lsh_r[6:0], sdi};
      ltgl_nxt  = ~ltgl_r;
    end
    // Word is loaded on the last edge of a byte so its MSB is ready for
    // the first edge of the next one; txw_r is held still meanwhile.
    if (lcnt_r == 3'h7 && ltx_req_s != lseen_r) begin
      lseen_nxt = ltx_req_s;
      sdo_nxt   = txw_r[23];
      ltx_nxt   = {txw_r[22:0], 1'b0};
      ltxc_nxt  = TX_LAST_BIT;
    end else if (ltxc_r != 5'h0) begin
      sdo_nxt  = ltx_r[23];
      ltxc_nxt = ltxc_r - 5'h1;
    end
  end

  // Data shifters need no reset: they fill before anything reads them.
  always_ff @(posedge link_clk) begin
    lsh_r   <= lsh_nxt;
    lbyte_r <= lbyte_nxt;
    ltx_r   <= ltx_nxt;
  end

  // The link clock may stand still through reset, so the framing state is
  // cleared by a registered copy of rst. Limitation: the host must keep
  // link_clk still while rst is released.
  always_ff @(posedge link_clk or posedge lrst_r) begin
    if (lrst_r) begin
      lcnt_r  <= 3'h0;
      ltgl_r  <= 1'b0;
      lseen_r <= 1'b0;
      ltxc_r  <= 5'h0;
      sdo_r   <= 1'b1;
    end else begin
      lcnt_r  <= lcnt_nxt;
      ltgl_r  <= ltgl_nxt;
      lseen_r <= lseen_nxt;
      ltxc_r  <= ltxc_nxt;
      sdo_r   <= sdo_nxt;
    end
  end

  assign rx_stb    = rx_s ^ rx_prev_r;
  assign rxb       = lbyte_r;
  assign fifo_full = (fcnt_r == (FAW+1)'(FIFO_DEPTH));
  assign cch       = cset_r[SETUP_CH_LSB +: CHW];

  function automatic logic [11:0] pick(input logic [3:0] p,
                                       input logic [23:0] w);
    pick = p[0] ? w[23:12] : w[11:0];
  endfunction

  always_comb begin
    state_nxt = state_r;
    ofs_nxt   = ofs_r;
    gain_nxt  = gain_r;
    setup_nxt = setup_r;
    fifo_nxt  = fifo_r;
    cfg_nxt   = cfg_r;
    wdata_nxt = wdata_r;
    txw_nxt   = txw_r;
    txt_nxt   = txt_r;
    cmd_nxt   = cmd_r;
    ones_nxt  = ones_r;
    wcnt_nxt  = wcnt_r;
    ptr_nxt   = ptr_r;
    rsm_nxt   = rsm_r;
    busy_nxt  = busy_r;
    scan_nxt  = scan_r;
    req_nxt   = req_r;
    cset_nxt  = cset_r;
    cop_nxt   = cop_r;
    push      = 1'b0;
    pop       = 1'b0;
    dset      = 1'b0;
    dclr      = 1'b0;
    soft_rst  = 1'b0;
    cfg_apply = 1'b0;
    calo_nxt  = ofs_r[cch];
    calg_nxt  = gain_r[cch];

    if (busy_r && !req_r && !fifo_full) begin
      req_nxt  = 1'b1;
      cset_nxt = pick(ptr_r, setup_r[ptr_r[CHW:1]]);
    end
    if (busy_r && req_r && conv_done) begin
      req_nxt = 1'b0;
      case (cop_r)
        OP_SELF_OFS, OP_SYS_OFS: begin
          ofs_nxt[cch] = conv_result;
          busy_nxt     = 1'b0;
        end
        OP_SELF_GAIN, OP_SYS_GAIN: begin
          gain_nxt[cch] = conv_result;
          busy_nxt      = 1'b0;
        end
        default: begin
          push = 1'b1;
          if (!scan_r) begin
            dset     = 1'b1;
            busy_nxt = 1'b0;
          end else if (ptr_r ==
                       cfg_r[CFG_DEPTH_LSB +: CFG_DEPTH_W]) begin
            dset     = 1'b1;
            ptr_nxt  = 4'h0;
            busy_nxt = cfg_r[CFG_LOOP_BIT];
          end else begin
            ptr_nxt = ptr_r + 4'h1;
          end
        end
      endcase
    end

    if (rx_stb) begin
      unique case (state_r)
        ST_INIT, ST_CMD: begin
          if (rxb == INIT_ONES_BYTE) begin
            ones_nxt = (ones_r == INIT_ONES_CNT) ? ones_r : ones_r + 4'h1;
          end else begin
            ones_nxt = 4'h0;
          end
          if (rxb == INIT_END_BYTE && ones_r == INIT_ONES_CNT) begin
            state_nxt = ST_CMD;
          end else if (state_r == ST_CMD) begin
            if (rxb == FIFO_POP_BYTE) begin
              if (fcnt_r != '0) begin
                pop     = 1'b1;
                txw_nxt = fifo_r[rp_r];
                txt_nxt = ~txt_r;
                dclr    = (fcnt_r == (FAW+1)'(1));
              end
            end else if (rxb[CMD_TYPE_BIT]) begin
              if (!busy_r && !rsm_r && (rxb[2:0] == OP_NORMAL ||
                  rxb[2:0] == OP_SELF_OFS || rxb[2:0] == OP_SELF_GAIN ||
                  rxb[2:0] == OP_SYS_OFS || rxb[2:0] == OP_SYS_GAIN)) begin
                busy_nxt = 1'b1;
                cop_nxt  = rxb[2:0];
                scan_nxt = cfg_r[CFG_MULTI_BIT] && rxb[2:0] == OP_NORMAL;
                ptr_nxt  = scan_nxt ? 4'h0 : rxb[CMD_PTR_LSB +: 4];
              end
            end else if (rxb[CMD_READ_BIT]) begin
              txt_nxt = ~txt_r;
              unique case (rxb[2:0])
                REG_OFS:   txw_nxt = ofs_r[rxb[CMD_CH_LSB +: CHW]];
                REG_GAIN:  txw_nxt = gain_r[rxb[CMD_CH_LSB +: CHW]];
                REG_SETUP: txw_nxt = setup_r[rxb[CMD_CH_LSB +: CHW]];
                REG_CFG: begin
                  txw_nxt = cfg_r;
                  cfg_nxt[CFG_VALID_BIT] = 1'b0;
                end
                default: txt_nxt = txt_r;
              endcase
            end else if (rxb[2:0] == REG_OFS || rxb[2:0] == REG_GAIN ||
                         rxb[2:0] == REG_CFG || rxb[2:0] == REG_SETUP) begin
              state_nxt = ST_WDATA;
              cmd_nxt   = rxb;
              wcnt_nxt  = 2'h0;
            end
          end
        end
        ST_WDATA: begin
          wdata_nxt = {wdata_r[15:0], rxb};
          wcnt_nxt  = wcnt_r + 2'h1;
          if (wcnt_r == 2'h2) begin
            state_nxt = ST_CMD;
            unique case (cmd_r[2:0])
              REG_OFS:   ofs_nxt[cmd_r[CMD_CH_LSB +: CHW]] = wdata_nxt;
              REG_GAIN:  gain_nxt[cmd_r[CMD_CH_LSB +: CHW]] = wdata_nxt;
              REG_SETUP: setup_nxt[cmd_r[CMD_CH_LSB +: CHW]] = wdata_nxt;
              default: begin
                cfg_apply = 1'b1;
                if (rsm_r) begin
                  rsm_nxt = wdata_nxt[CFG_RESET_BIT];
                end else if (wdata_nxt[CFG_RESET_BIT]) begin
                  soft_rst = 1'b1;
                end else begin
                  // only the writable bits are taken from the word
                  cfg_nxt = (wdata_nxt & CFG_WR_MASK)
                          | (cfg_nxt & ~CFG_WR_MASK);
                end
              end
            endcase
          end
        end
      endcase
    end

    // Hardware set wins over the clearing pop.
    done_nxt = dset | (done_r & ~dclr);
    cfg_nxt[CFG_DONE_BIT] = done_nxt;
    cfg_nxt  = cfg_nxt & CFG_USED_MASK;

    fcnt_nxt = fcnt_r;
    wp_nxt   = wp_r;
    rp_nxt   = rp_r;
    if (push) begin
      fifo_nxt[wp_r] = conv_result;
      wp_nxt         = wp_r + 1'b1;
    end
    if (pop) begin
      rp_nxt = rp_r + 1'b1;
    end
    if (push && !pop) begin
      fcnt_nxt = fcnt_r + 1'b1;
    end else if (pop && !push) begin
      fcnt_nxt = fcnt_r - 1'b1;
    end

    if (soft_rst) begin
      ofs_nxt   = '{default: OFS_RST_VAL};
      gain_nxt  = '{default: GAIN_RST_VAL};
      setup_nxt = '{default: SETUP_RST_VAL};
      cfg_nxt   = CFG_RST_VAL;
      rsm_nxt   = 1'b1;
      busy_nxt  = 1'b0;
      req_nxt   = 1'b0;
      done_nxt  = 1'b0;
      fcnt_nxt  = '0;
      wp_nxt    = '0;
      rp_nxt    = '0;
    end
  end

  always_ff @(posedge clock) begin
    lrst_r    <= rst;
    fifo_r    <= fifo_nxt;
    wdata_r   <= wdata_nxt;
    txw_r     <= txw_nxt;
    cmd_r     <= cmd_nxt;
    cset_r    <= cset_nxt;
    cop_r     <= cop_nxt;
    calo_r    <= calo_nxt;
    calg_r    <= calg_nxt;
    if (rst) begin
      state_r <= ST_INIT;
      rx_prev_r <= 1'b0;
      ofs_r   <= '{default: OFS_RST_VAL};
      gain_r  <= '{default: GAIN_RST_VAL};
      setup_r <= '{default: SETUP_RST_VAL};
      cfg_r   <= CFG_RST_VAL;
      txt_r   <= 1'b0;
      ones_r  <= 4'h0;
      wcnt_r  <= 2'h0;
      ptr_r   <= 4'h0;
      rsm_r   <= 1'b0;
      busy_r  <= 1'b0;
      scan_r  <= 1'b0;
      done_r  <= 1'b0;
      req_r   <= 1'b0;
      wp_r    <= '0;
      rp_r    <= '0;
      fcnt_r  <= '0;
    end else begin
      state_r <= state_nxt;
      rx_prev_r <= rx_s;
      ofs_r   <= ofs_nxt;
      gain_r  <= gain_nxt;
      setup_r <= setup_nxt;
      cfg_r   <= cfg_nxt;
      txt_r   <= txt_nxt;
      ones_r  <= ones_nxt;
      wcnt_r  <= wcnt_nxt;
      ptr_r   <= ptr_nxt;
      rsm_r   <= rsm_nxt;
      busy_r  <= busy_nxt;
      scan_r  <= scan_nxt;
      done_r  <= done_nxt;
      req_r   <= req_nxt;
      wp_r    <= wp_nxt;
      rp_r    <= rp_nxt;
      fcnt_r  <= fcnt_nxt;
    end
  end

  // completion flag on the data line
  assign sdo        = sdo_r;
  assign conv_req   = req_r;
  assign conv_setup = cset_r;
  assign conv_op    = cop_r;
  assign cal_offset = calo_r;
  assign cal_gain   = calg_r;
  assign cfg_out    = cfg_r;

  default clocking cb_core @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_launch;
    busy_r && !req_r && !fifo_full && !soft_rst ##1 req_r;
  endsequence

  sequence s_scan_end;
    busy_r && req_r && conv_done && scan_r && cop_r == OP_NORMAL
      && !soft_rst
      && ptr_r == cfg_r[CFG_DEPTH_LSB +: CFG_DEPTH_W];
  endsequence

  a_init_entry: assert property (rx_stb && state_r == ST_INIT
      && rxb == INIT_END_BYTE && ones_r == INIT_ONES_CNT
      |=> state_r == ST_CMD)
    else $error("init sequence did not enter command mode");
  a_launch_setup: assert property (s_launch
      |-> conv_setup == pick($past(ptr_r),
                             setup_r[$past(ptr_r[CHW:1])]))
    else $error("launched instruction differs from pointer");
  a_valid_clear: assert property (rx_stb && state_r == ST_CMD
      && rxb == {1'b0, 3'h0, 1'b1, REG_CFG} |=> !cfg_r[CFG_VALID_BIT])
    else $error("reset-valid flag not cleared by read");
  a_soft_reset: assert property (soft_rst
      |=> cfg_r == CFG_RST_VAL && rsm_r && fcnt_r == '0 && !busy_r)
    else $error("soft reset did not restore registers");
  a_rs_discard: assert property (cfg_apply && rsm_r
      |=> cfg_r == $past(cfg_r) && rsm_r == $past(wdata_nxt[7]))
    else $error("configuration changed while leaving reset");
  a_gain_store: assert property (busy_r && req_r && conv_done
      && cop_r == OP_SELF_GAIN && !soft_rst
      |=> gain_r[$past(cch)] == $past(conv_result) && !busy_r)
    else $error("gain calibration result not stored");
  a_scan_push: assert property (busy_r && req_r && conv_done
      && cop_r == OP_NORMAL && !pop && !soft_rst
      |=> fcnt_r == $past(fcnt_r) + 1'b1)
    else $error("conversion result not pushed");
  a_scan_stop: assert property (s_scan_end ##0 !cfg_r[CFG_LOOP_BIT]
      |=> !busy_r && done_r ##1 !req_r)
    else $error("scan did not stop at programmed depth");
  a_scan_step: assert property (busy_r && req_r && conv_done
      && scan_r && cop_r == OP_NORMAL && !soft_rst
      && ptr_r != cfg_r[CFG_DEPTH_LSB +: CFG_DEPTH_W]
      |=> ptr_r == $past(ptr_r) + 4'h1)
    else $error("scan did not advance to next instruction");

endmodule

//--- tb/adcrc_host.sv
// Host model: drives the three-wire link byte by byte, samples sdo.
// Assumes the controller samples sdi and shifts sdo on link_clk rising.
`timescale 1ns/1ps
module adcrc_host
  import adcrc_pkg::*;
#(
  parameter int HALF = 16
) (
  output logic      link_clk,
  output logic      sdi,
  input  wire logic sdo
);
  initial begin
    link_clk = 1'b0;
    sdi      = 1'b1;
  end

  // The clock stands still between bytes and sdi flips when idle, so a
  // stale level is never mistaken for data.
  task automatic xfer(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sdi = b[i];
      #HALF;
      r[i] = sdo;
      link_clk = 1'b1;
      #HALF;
      link_clk = 1'b0;
    end
    sdi = ~sdi;
  endtask

  task automatic init_port();
    logic [7:0] r;
    repeat (INIT_ONES_CNT) xfer(INIT_ONES_BYTE, r);
    xfer(INIT_END_BYTE, r);
  endtask

  task automatic wr(input logic [7:0] c, input logic [23:0] w);
    logic [7:0] r;
    xfer(c, r);
    for (int k = 2; k >= 0; k--) xfer(w[8*k +: 8], r);
  endtask

  // Reads and pops alike answer one byte late, so a spacer byte follows.
  task automatic rd(input logic [7:0] c, output logic [23:0] w,
                    output logic [7:0] f);
    logic [7:0] r;
    xfer(c, f);
    xfer(INIT_ONES_BYTE, r);
    for (int k = 2; k >= 0; k--) begin
      xfer(INIT_ONES_BYTE, r);
      w[8*k +: 8] = r;
    end
  endtask
endmodule

//--- tb/adc_register_controller_test.sv
// Bench of the converter register controller with a host link model.
// Assumes the front end is modelled here; results come from an LFSR.
`timescale 1ns/1ps
module adc_register_controller_test
  import adcrc_pkg::*;
;
  localparam int NCH = 4;
  logic        clock;
  logic        rst;
  logic        link_clk;
  logic        sdi;
  logic        sdo;
  logic        conv_req;
  logic        conv_done;
  logic [11:0] conv_setup;
  logic [2:0]  conv_op;
  logic [23:0] conv_result;
  logic [23:0] cal_offset;
  logic [23:0] cal_gain;
  logic [23:0] cfg_out;
  int          err_count;
  int          n_tests;
  logic [31:0] seed;
  logic [23:0] m_ofs[NCH];
  logic [23:0] m_gain[NCH];
  logic [23:0] m_setup[NCH];
  logic [23:0] m_fifo[$];
  logic [14:0] m_exp[$];
  logic        seen_r;
  logic [2:0]  wait_r;
  logic [23:0] v;

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  adcrc_ctrl #(.NCH(NCH), .FIFO_DEPTH(8)) i_dut (
    .clock(clock), .rst(rst), .link_clk(link_clk), .sdi(sdi),
    .sdo(sdo), .conv_req(conv_req), .conv_setup(conv_setup),
    .conv_op(conv_op), .conv_done(conv_done),
    .conv_result(conv_result), .cal_offset(cal_offset),
    .cal_gain(cal_gain), .cfg_out(cfg_out));

  adcrc_host i_host (.link_clk(link_clk), .sdi(sdi), .sdo(sdo));

  function automatic logic [23:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[23:0];
  endfunction

  task automatic check(input logic [23:0] s, input logic [23:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic end_sim();
    $display("errors=%0d checks=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Each result is compared with the model's pending instruction.
  task automatic model_result(input logic [23:0] r);
    logic [14:0] e;
    if (m_exp.size() == 0) begin
      check(24'h1, 24'h0);
      return;
    end
    e = m_exp.pop_front();
    check(24'(conv_setup), 24'(e[11:0]));
    check(24'(conv_op), 24'(e[14:12]));
    check(cal_offset, m_ofs[e[1:0]]);
    check(cal_gain, m_gain[e[1:0]]);
    case (e[14:12])
      OP_NORMAL: m_fifo.push_back(r);
      OP_SELF_OFS, OP_SYS_OFS: m_ofs[e[1:0]] = r;
      default: m_gain[e[1:0]] = r;
    endcase
  endtask

  // Front end answers every launch after two, four, six or eight cycles.
  always @(posedge clock) begin
    conv_done <= 1'b0;
    if (rst || !conv_req) begin
      seen_r <= 1'b0;
      wait_r <= 3'h0;
    end else if (!seen_r) begin
      seen_r <= 1'b1;
      wait_r <= 3'(rnd()) | 3'h1;
    end else if (wait_r == 3'h1) begin
      wait_r <= 3'h0;
      v = rnd();
      conv_done <= 1'b1;
      conv_result <= v;
      model_result(v);
    end else if (wait_r != 3'h0) begin
      wait_r <= wait_r - 3'h1;
    end
  end

  function automatic logic [7:0] rc(int ch, logic r, logic [2:0] s);
    return {1'b0, 3'(ch), r, s};
  endfunction

  function automatic logic [11:0] ins(int p);
    return p[0] ? m_setup[p / 2][23:12] : m_setup[p / 2][11:0];
  endfunction

  task automatic rd_chk(input logic [7:0] c, input logic [23:0] e);
    logic [23:0] w;
    logic [7:0]  f;
    i_host.rd(c, w, f);
    check(w, e);
  endtask

  task automatic pop_chk();
    logic [23:0] w;
    logic [7:0]  f;
    i_host.rd(FIFO_POP_BYTE, w, f);
    check(24'(f[0]), 24'h0);
    check(w, m_fifo.pop_front());
  endtask

  task automatic conv(input int p, input logic [2:0] op);
    m_exp.push_back({op, ins(p)});
    i_host.wr({1'b1, 4'(p), op}, 24'hffffff);
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 3000 && m_exp.size() != 0; i++) @(posedge clock);
    if (m_exp.size() != 0) begin
      err_count++;
      end_sim();
    end
    repeat (300) @(posedge clock);
  endtask

  initial begin
    #500000;
    err_count++;
    end_sim();
  end

  initial begin
    logic [2:0] ops[5];
    ops = '{OP_NORMAL, OP_SELF_OFS, OP_SELF_GAIN, OP_SYS_OFS, OP_SYS_GAIN};
    seed = 32'hcb3d;
    err_count = 0;
    n_tests = 0;
    rst = 1'b1;
    conv_done = 1'b0;
    conv_result = 24'h0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (20) @(posedge clock);
    #3;
    i_host.init_port();
    rd_chk(rc(0, 1'b1, REG_CFG), CFG_RST_VAL);
    rd_chk(rc(0, 1'b1, REG_CFG), 24'h0);
    for (int c = 0; c < NCH; c++) begin
      m_ofs[c] = OFS_RST_VAL;
      m_gain[c] = GAIN_RST_VAL;
      rd_chk(rc(c, 1'b1, REG_OFS), OFS_RST_VAL);
      rd_chk(rc(c, 1'b1, REG_GAIN), GAIN_RST_VAL);
      rd_chk(rc(c, 1'b1, REG_SETUP), SETUP_RST_VAL);
    end
    i_host.wr(rc(0, 1'b0, REG_CFG), 24'hffff7f);
    repeat (8) @(posedge clock);
    check(cfg_out, 24'hffff7f & CFG_WR_MASK);
    i_host.wr(rc(0, 1'b0, REG_CFG), 24'h0);
    for (int c = 0; c < NCH; c++) begin
      m_ofs[c] = rnd();
      m_gain[c] = rnd();
      m_setup[c] = {rnd() & 24'hffcffc} | {12'(c), 12'(c)};
      i_host.wr(rc(c, 1'b0, REG_OFS), m_ofs[c]);
      i_host.wr(rc(c, 1'b0, REG_GAIN), m_gain[c]);
      i_host.wr(rc(c, 1'b0, REG_SETUP), m_setup[c]);
      rd_chk(rc(c, 1'b1, REG_SETUP), m_setup[c]);
    end
    for (int i = 0; i < 5; i++) begin
      conv(i, ops[i]);
      wait_idle();
    end
    for (int c = 0; c < NCH; c++) begin
      rd_chk(rc(c, 1'b1, REG_OFS), m_ofs[c]);
      rd_chk(rc(c, 1'b1, REG_GAIN), m_gain[c]);
    end
    pop_chk();
    i_host.wr(rc(0, 1'b0, REG_CFG), 24'h008800);
    for (int p = 0; p < 3; p++) m_exp.push_back({OP_NORMAL, ins(p)});
    i_host.wr({1'b1, 4'h0, OP_NORMAL}, 24'hffffff);
    wait_idle();
    repeat (3) pop_chk();
    check(24'(sdo), 24'h1);
    // continuous scan fills the FIFO, then stalls
    i_host.wr(rc(0, 1'b0, REG_CFG), 24'h00c800);
    for (int p = 0; p < 8; p++) m_exp.push_back({OP_NORMAL, ins(p % 3)});
    i_host.wr({1'b1, 4'h0, OP_NORMAL}, 24'hffffff);
    wait_idle();
    m_fifo.delete();
    i_host.wr(rc(0, 1'b0, REG_CFG), 24'h000080);
    i_host.wr(rc(0, 1'b0, REG_CFG), 24'h008800);
    repeat (8) @(posedge clock);
    check(cfg_out, CFG_RST_VAL);
    rd_chk(rc(0, 1'b1, REG_CFG), CFG_RST_VAL);
    rd_chk(rc(1, 1'b1, REG_OFS), OFS_RST_VAL);
    rd_chk(rc(1, 1'b1, REG_GAIN), GAIN_RST_VAL);
    rd_chk(rc(1, 1'b1, REG_SETUP), SETUP_RST_VAL);
    end_sim();
  end
endmodule
